// *** core/pic8_host.sv ***
// Processor-side glue: drives the status and control pins from software registers
// over Avalon-MM, latches the one-clock interrupt and forms the restart byte.
// Assumes peripherals hold their requests until serviced.
`timescale 1ns/1ns
module pic8_host
	import pic8_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	pic8_link_if.host        lnk,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	input  wire logic [7:0]  periph_req,
	input  wire logic        partner_int_n
);
	import pic8_pkg::*;

	logic                     ack_q;
	logic                     wr_go;
	logic [2:0]               ctrl_q;
	logic                     strobe_q;
	pic8_level_t              st_level_q;
	logic                     st_cmp_q;
	logic [7:0]               opcode_q;
	logic                     op_valid_q;
	logic [PIC8_IRQ_BITS-1:0] irq_stat_q;
	logic [PIC8_IRQ_BITS-1:0] irq_mask_q;
	logic [PIC8_IRQ_BITS-1:0] irq_ev;
	logic                     int_low;

	// Every access waits exactly one cycle
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_go           = avs_write & ack_q;
	assign int_low         = ~lnk.int_line_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & ~ack_q) begin
			unique case (avs_address)
				PIC8_REG_CTRL:     avs_readdata <= {29'h0, ctrl_q};
				PIC8_REG_STATUS:   avs_readdata <= {28'h0, st_cmp_q, st_level_q};
				PIC8_REG_VECTOR:   avs_readdata <= {23'h0, op_valid_q, opcode_q};
				PIC8_REG_IRQ_STAT: avs_readdata <= {30'h0, irq_stat_q};
				PIC8_REG_IRQ_MASK: avs_readdata <= {30'h0, irq_mask_q};
				default:           avs_readdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= PIC8_CTRL_RESET;
		end else if (wr_go && avs_address == PIC8_REG_CTRL) begin
			ctrl_q <= avs_writedata[2:0];
		end
	end

	// A status write pulses the strobe low for one clock
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strobe_q   <= 1'b0;
			st_level_q <= '0;
			st_cmp_q   <= 1'b0;
		end else begin
			strobe_q <= wr_go && avs_address == PIC8_REG_STATUS;
			if (wr_go && avs_address == PIC8_REG_STATUS) begin
				st_level_q <= avs_writedata[PIC8_LW-1:0];
				st_cmp_q   <= avs_writedata[PIC8_STW_CMP];
			end
		end
	end

	// Interrupt is only one clock wide, so it is caught here with the code
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			opcode_q   <= 8'hff;
			op_valid_q <= 1'b0;
		end else if (int_low) begin
			opcode_q   <= pic8_restart(lnk.vector_code_n);
			op_valid_q <= 1'b1;
		end else if (strobe_q) begin
			op_valid_q <= 1'b0;
		end
	end

	assign irq_ev[PIC8_IRQ_OWN]   = int_low & partner_int_n;
	assign irq_ev[PIC8_IRQ_WIRED] = int_low & ~partner_int_n;

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_stat_q <= '0;
		end else if (wr_go && avs_address == PIC8_REG_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~avs_writedata[PIC8_IRQ_BITS-1:0]) | irq_ev;
		end else begin
			irq_stat_q <= irq_stat_q | irq_ev;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_mask_q <= '0;
		end else if (wr_go && avs_address == PIC8_REG_IRQ_MASK) begin
			irq_mask_q <= avs_writedata[PIC8_IRQ_BITS-1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// Peripherals own their lines and must hold them until serviced
	assign lnk.request_lines_n               = ~periph_req;
	// Level written inverted on the active-low status pins
	assign lnk.status_level_inputs_n         = ~st_level_q;
	assign lnk.status_group_sel_n            = st_cmp_q;
	assign lnk.current_status_write_strobe_n = ~strobe_q;
	assign lnk.accept_gate_enable            = ctrl_q[PIC8_CTRL_GATE];
	assign lnk.chip_level_enable_n           = ctrl_q[PIC8_CTRL_CHIP_N];
	assign lnk.group_enable_in               = ctrl_q[PIC8_CTRL_GRP];
	assign lnk.cascade_int_n                 = partner_int_n;
endmodule // pic8_host

// *** core/pic8_pkg.sv ***
// Constants, types and helper functions shared by both ends of the
// eight-level priority interrupt link. No clocks or reset live here.
package pic8_pkg;
	localparam int          PIC8_LEVELS       = 8;
	localparam int          PIC8_LW           = 3;
	// Host register word offsets (byte address = 4 * index)
	localparam logic [2:0]  PIC8_REG_CTRL     = 3'h0;
	localparam logic [2:0]  PIC8_REG_STATUS   = 3'h1;
	localparam logic [2:0]  PIC8_REG_VECTOR   = 3'h2;
	localparam logic [2:0]  PIC8_REG_IRQ_STAT = 3'h3;
	localparam logic [2:0]  PIC8_REG_IRQ_MASK = 3'h4;
	// Control register fields
	localparam int          PIC8_CTRL_GATE    = 0;
	localparam int          PIC8_CTRL_CHIP_N  = 1;
	localparam int          PIC8_CTRL_GRP     = 2;
	localparam logic [2:0]  PIC8_CTRL_RESET   = 3'h4;
	// Status write fields
	localparam int          PIC8_STW_CMP      = 3;
	// Vector register fields
	localparam int          PIC8_VEC_VALID    = 8;
	// Interrupt status fields
	localparam int          PIC8_IRQ_OWN      = 0;
	localparam int          PIC8_IRQ_WIRED    = 1;
	localparam int          PIC8_IRQ_BITS     = 2;
	// Device reset values
	localparam logic [2:0]  PIC8_CS_RESET     = 3'h0;
	localparam logic        PIC8_CMP_RESET    = 1'b0;
	localparam logic        PIC8_DIS_RESET    = 1'b0;

	typedef logic [PIC8_LW-1:0] pic8_level_t;

	// Strict priority test: a above b
	function automatic logic pic8_higher(pic8_level_t a, pic8_level_t b);
		return a > b;
	endfunction

	// Restart opcode around an inverted vector code
	function automatic logic [7:0] pic8_restart(pic8_level_t code_n);
		return {2'b11, code_n, 3'b111};
	endfunction
endpackage

// *** core/pic8_link_if.sv ***
// Pin-level link between the controller and its processor-side glue.
// Open-collector outputs are resolved here from their enables.
`timescale 1ns/1ns
interface pic8_link_if;
	logic [7:0] request_lines_n;
	logic [2:0] status_level_inputs_n;
	logic       status_group_sel_n;
	logic       current_status_write_strobe_n;
	logic       accept_gate_enable;
	logic       chip_level_enable_n;
	logic       group_enable_in;
	logic       group_enable_out;
	logic [2:0] vector_code_n_o;
	logic [2:0] vector_code_n_oe;
	logic       int_n_o;
	logic       int_n_oe;
	logic       cascade_int_n;
	logic [2:0] vector_code_n;
	logic       int_line_n;

	// Pulled-up open-collector wires; cascade partners share the int line
	assign vector_code_n = ~vector_code_n_oe | vector_code_n_o;
	assign int_line_n    = (~int_n_oe | int_n_o) & cascade_int_n;

	modport dev (
		input  request_lines_n, status_level_inputs_n, status_group_sel_n,
		input  current_status_write_strobe_n, accept_gate_enable,
		input  chip_level_enable_n, group_enable_in, int_line_n,
		output group_enable_out, vector_code_n_o, vector_code_n_oe,
		output int_n_o, int_n_oe
	);
	modport host (
		output request_lines_n, status_level_inputs_n, status_group_sel_n,
		output current_status_write_strobe_n, accept_gate_enable,
		output chip_level_enable_n, group_enable_in, cascade_int_n,
		input  group_enable_out, vector_code_n, int_line_n
	);
endinterface

// *** core/pic8_prio_enc.sv ***
// Priority encoder over active-high requests.
// Highest index wins; purely combinational.
`timescale 1ns/1ns
module pic8_prio_enc #(
	parameter int N  = 8,
	parameter int LW = 3
) (
	input  wire logic [N-1:0]  req,
	output logic               valid,
	output logic [LW-1:0]      level
);
	always_comb begin
		valid = 1'b0;
		level = '0;
		for (int i = 0; i < N; i++) begin
			if (req[i]) begin
				valid = 1'b1;
				level = LW'(i);
			end
		end
	end
endmodule // pic8_prio_enc

// *** core/pic8_dev.sv ***
// Controller end: priority encoder, status register, priority compare,
// interrupt and disable flops, cascade enable and open-collector vector.
// Assumes all pins are synchronous to clk_sys; partners share int_line_n.
`timescale 1ns/1ns
module pic8_dev
	import pic8_pkg::*;
#(
	parameter int N = pic8_pkg::PIC8_LEVELS
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	pic8_link_if.dev               lnk,
	output pic8_pkg::pic8_level_t  cur_level,
	output logic                   cmp_enabled,
	output logic                   disable_flop,
	output pic8_pkg::pic8_level_t  latched_level,
	output logic                   latched_valid,
	output logic                   int_active
);
	import pic8_pkg::*;

	logic [N-1:0] req_act;
	logic         enc_valid;
	pic8_level_t  enc_level;
	logic         chip_en;
	logic         cs_write;
	logic         prio_ok;
	logic         pending;
	logic         accept_d;
	logic         wired_int;

	pic8_level_t  cs_level_q;
	logic         cmp_en_q;
	logic         disable_q;
	logic         int_q;
	pic8_level_t  vec_q;
	logic         vec_valid_q;

	// Active-low request pins, level zero lowest
	assign req_act = ~lnk.request_lines_n;

	pic8_prio_enc #(
		.N  (N),
		.LW (PIC8_LW)
	) u_enc (
		.req   (req_act),
		.valid (enc_valid),
		.level (enc_level)
	);

	assign chip_en   = ~lnk.chip_level_enable_n;
	assign cs_write  = ~lnk.current_status_write_strobe_n;
	assign wired_int = ~lnk.int_line_n;

	// Compare bypassed when the last status write had group select low
	assign prio_ok = ~cmp_en_q | pic8_higher(enc_level, cs_level_q);

	// A request that passes the compare while the chip is enabled counts as pending for the chain
	assign pending = chip_en & enc_valid & prio_ok;

	// Condition gate in front of the interrupt flop
	assign accept_d = lnk.group_enable_in
	                & lnk.accept_gate_enable
	                & chip_en
	                & enc_valid
	                & prio_ok
	                & ~disable_q;

	// Cascade enable; a low input propagates down the chain
	assign lnk.group_enable_out = lnk.group_enable_in & ~pending;

	// Current status register, loaded while the strobe is low
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cs_level_q <= PIC8_CS_RESET;
			cmp_en_q   <= PIC8_CMP_RESET;
		end else if (cs_write) begin
			cs_level_q <= ~lnk.status_level_inputs_n;
			cmp_en_q   <= lnk.status_group_sel_n;
		end
	end

	// Interrupt flop: one clock wide, blocked while the line is already low
	// so that the disable flop has time to close the gate
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			int_q <= 1'b0;
		end else begin
			int_q <= accept_d & ~wired_int;
		end
	end

	// Disable flop: any low on the shared line sets it, status write clears.
	// Set wins over a clear in the same cycle so no interrupt slips through.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			disable_q <= PIC8_DIS_RESET;
		end else if (wired_int) begin
			disable_q <= 1'b1;
		end else if (cs_write) begin
			disable_q <= 1'b0;
		end
	end

	// Request latch: level captured on acceptance, unaccepted ones are not
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			vec_q       <= '0;
			vec_valid_q <= 1'b0;
		end else if (accept_d) begin
			vec_q       <= enc_level;
			vec_valid_q <= 1'b1;
		end else if (cs_write) begin
			vec_valid_q <= 1'b0;
		end
	end

	// Open-collector pins: a code bit of one pulls its wire low.
	// Floated entirely when the chip is disabled or nothing is latched.
	assign lnk.vector_code_n_o  = 3'h0;
	assign lnk.vector_code_n_oe = (chip_en & vec_valid_q) ? vec_q : 3'h0;
	assign lnk.int_n_o          = 1'b0;
	assign lnk.int_n_oe         = int_q;

	assign cur_level     = cs_level_q;
	assign cmp_enabled   = cmp_en_q;
	assign disable_flop  = disable_q;
	assign latched_level = vec_q;
	assign latched_valid = vec_valid_q;
	assign int_active    = int_q;
endmodule // pic8_dev

// *** test/pic8_link_monitor.sv ***
// Concurrent checks on the controller link pins.
// Assumes one clock domain; placed beside the link interface.
`timescale 1ns/1ns
module pic8_link_monitor (
	input wire logic       clk_sys,
	input wire logic       resetn,
	input wire logic [7:0] request_lines_n,
	input wire logic [2:0] status_level_inputs_n,
	input wire logic       status_group_sel_n,
	input wire logic       current_status_write_strobe_n,
	input wire logic       accept_gate_enable,
	input wire logic       chip_level_enable_n,
	input wire logic       group_enable_in,
	input wire logic       group_enable_out,
	input wire logic [2:0] vector_code_n,
	input wire logic       int_n_oe,
	input wire logic       int_line_n
);
	logic [2:0] lvl_q;
	logic       cmp_q;
	logic       dis_q;
	logic       acc;
	logic       pend;

	function automatic logic [2:0] top_lvl(input logic [7:0] r);
		top_lvl = 3'h0;
		for (int i = 0; i < 8; i++)
			if (r[i])
				top_lvl = i[2:0];
	endfunction

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lvl_q <= 3'h0;
			cmp_q <= 1'b0;
		end else if (!current_status_write_strobe_n) begin
			lvl_q <= ~status_level_inputs_n;
			cmp_q <= status_group_sel_n;
		end
	end

	// Wired line low wins over a same-edge status write
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			dis_q <= 1'b0;
		else if (!int_line_n)
			dis_q <= 1'b1;
		else if (!current_status_write_strobe_n)
			dis_q <= 1'b0;
	end

	// Pending ignores the gate and disable flop, so the chain stays blocked
	assign pend = !chip_level_enable_n && request_lines_n != 8'hff
		&& (!cmp_q || top_lvl(~request_lines_n) > lvl_q);
	assign acc = accept_gate_enable && group_enable_in && !dis_q && int_line_n && pend;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_pulse;
		int_n_oe ##1 !int_n_oe;
	endsequence
	sequence s_line_no_write;
		!int_line_n ##1 current_status_write_strobe_n;
	endsequence

	int_one_clock_a: assert property ($rose(int_n_oe) |-> s_pulse)
		else $error("int pulse too long");
	accept_fires_a: assert property (acc |=> s_pulse)
		else $error("accepted request gave no int");
	accept_blocked_a: assert property (!acc |=> !int_n_oe)
		else $error("int without acceptance");
	disable_holds_a: assert property (s_line_no_write |=> !int_n_oe)
		else $error("int while disabled");
	vector_code_a: assert property (
		$rose(int_n_oe) && !chip_level_enable_n
		|-> vector_code_n == ~top_lvl(~$past(request_lines_n)))
		else $error("wrong vector code");
	vector_float_a: assert property (
		chip_level_enable_n && $past(chip_level_enable_n) |-> vector_code_n == 3'h7)
		else $error("vector driven while chip off");
	group_busy_a: assert property (
		!group_enable_in || int_n_oe || pend |-> !group_enable_out)
		else $error("group out high while busy");
	group_free_a: assert property (
		group_enable_in && !pend |-> group_enable_out)
		else $error("group out low with nothing pending");
	strobe_once_a: assert property (
		$fell(current_status_write_strobe_n) |=> current_status_write_strobe_n)
		else $error("status strobe too long");
endmodule // pic8_link_monitor

// *** test/tb.sv ***
// Bench: controller and host glue joined by the link, software side over
// Avalon-MM; peripheral and partner interrupt lines driven directly.
`timescale 1ns/1ns
module tb;
	import pic8_pkg::*;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic        dis_flop;
	logic [7:0]  periph_req = 8'h00;
	logic        partner_int_n = 1'b1;
	logic [31:0] exp_q[$];
	logic [2:0]  blk[3] = '{3'h4, 3'h7, 3'h1};
	int          n_fail = 0;
	int          compares = 0;
	int          cycles = 0;
	integer      seed = 32'h8d7aff47;

	always #25 clk_sys = ~clk_sys;

	pic8_link_if pic8_link_if_i ();
	pic8_dev pic8_dev_i (.clk_sys, .resetn, .lnk(pic8_link_if_i), .cur_level(),
		.cmp_enabled(), .disable_flop(dis_flop), .latched_level(),
		.latched_valid(), .int_active());
	pic8_host pic8_host_i (.clk_sys, .resetn, .lnk(pic8_link_if_i), .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
		.periph_req, .partner_int_n);
	pic8_link_monitor pic8_link_monitor_i (.clk_sys, .resetn,
		.request_lines_n(pic8_link_if_i.request_lines_n),
		.status_level_inputs_n(pic8_link_if_i.status_level_inputs_n),
		.status_group_sel_n(pic8_link_if_i.status_group_sel_n),
		.current_status_write_strobe_n(pic8_link_if_i.current_status_write_strobe_n),
		.accept_gate_enable(pic8_link_if_i.accept_gate_enable),
		.chip_level_enable_n(pic8_link_if_i.chip_level_enable_n),
		.group_enable_in(pic8_link_if_i.group_enable_in),
		.group_enable_out(pic8_link_if_i.group_enable_out),
		.vector_code_n(pic8_link_if_i.vector_code_n),
		.int_n_oe(pic8_link_if_i.int_n_oe), .int_line_n(pic8_link_if_i.int_line_n));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test;
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Extra edge first so a release and the next request never share a step
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	function automatic logic [31:0] vexp(input logic [2:0] l);
		return {23'h0, 1'b1, 2'b11, ~l, 3'b111};
	endfunction

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			end_of_test();
		end
		if (avs_read && avs_waitrequest === 1'b0)
			check("readdata", avs_readdata, exp_q.pop_front());
	end

	initial begin
		settle(2);
		resetn <= 1'b1;
		rd(PIC8_REG_CTRL, 32'h4);
		bus(1'b1, 3'h7, 32'hffff_ffff);
		rd(3'h7, 32'h0);
		bus(1'b1, PIC8_REG_IRQ_MASK, 32'h1);
		rd(PIC8_REG_IRQ_MASK, 32'h1);
		bus(1'b1, PIC8_REG_CTRL, 32'h5);
		for (int l = 0; l < 8; l++) begin
			periph_req <= (8'h01 << l) | (8'($random(seed)) & ((8'h01 << l) - 8'h01));
			bus(1'b1, PIC8_REG_STATUS, 32'h0);
			settle(4);
			check("irq", 32'(irq), 32'h1);
			check("group_out", 32'(pic8_link_if_i.group_enable_out), 32'h0);
			rd(PIC8_REG_VECTOR, vexp(l[2:0]));
			rd(PIC8_REG_IRQ_STAT, 32'h1);
			bus(1'b1, PIC8_REG_IRQ_STAT, 32'h3);
			settle(1);
			check("irq", 32'(irq), 32'h0);
		end
		bus(1'b1, PIC8_REG_IRQ_MASK, 32'h0);
		periph_req <= 8'h08;
		bus(1'b1, PIC8_REG_STATUS, 32'hb);
		settle(4);
		rd(PIC8_REG_IRQ_STAT, 32'h0);
		rd(PIC8_REG_STATUS, 32'hb);
		check("group_out", 32'(pic8_link_if_i.group_enable_out), 32'h1);
		periph_req <= 8'h18;
		settle(4);
		check("irq", 32'(irq), 32'h0);
		rd(PIC8_REG_IRQ_STAT, 32'h1);
		rd(PIC8_REG_VECTOR, vexp(3'h4));
		bus(1'b1, PIC8_REG_IRQ_MASK, 32'h1);
		settle(1);
		check("irq", 32'(irq), 32'h1);
		bus(1'b1, PIC8_REG_IRQ_STAT, 32'h3);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, PIC8_REG_CTRL, 32'(blk[k]));
			bus(1'b1, PIC8_REG_STATUS, 32'h0);
			settle(4);
			rd(PIC8_REG_IRQ_STAT, 32'h0);
			bus(1'b1, PIC8_REG_CTRL, 32'h5);
			settle(4);
			rd(PIC8_REG_IRQ_STAT, 32'h1);
			bus(1'b1, PIC8_REG_IRQ_STAT, 32'h3);
		end
		periph_req <= 8'h00;
		bus(1'b1, PIC8_REG_STATUS, 32'h0);
		settle(2);
		partner_int_n <= 1'b0;
		settle(1);
		partner_int_n <= 1'b1;
		periph_req <= 8'h40;
		settle(4);
		rd(PIC8_REG_IRQ_STAT, 32'h2);
		check("disable_flop", 32'(dis_flop), 32'h1);
		bus(1'b1, PIC8_REG_IRQ_STAT, 32'h3);
		bus(1'b1, PIC8_REG_STATUS, 32'h0);
		settle(4);
		rd(PIC8_REG_IRQ_STAT, 32'h1);
		rd(PIC8_REG_VECTOR, vexp(3'h6));
		end_of_test();
	end
endmodule // tb
